//--- hw/adcpr_top.sv
// Converter control: port configuration, SAR sequencing, result pair.
// Assumes an APB master on CLK_I and an analog comparator and RC
// oscillator whose outputs arrive asynchronously on pins.
//
// What this block does
// - Justify bit one: result high byte upper six bits read zero.
// - Justify bit zero: result low byte lower six bits read zero.
// - Port configuration bits six to four read as zero.
// - Port code decodes to eight per-pin analog or digital selects.
// - Port code picks references: supply or pin three, ground or pin two.
// - Completion loads the 10-bit result into the byte pair.
// - Completion clears start/busy bit two and sets the done flag.
// - Two bit periods pass after a conversion before sampling again.
// - Hold capacitor stays disconnected during that two-period wait.
// - Hold capacitor is never discharged at conversion end.
// - Writing start while powered starts; bit reads one while busy.
// - Clock select: 2, 8, 32 system clocks, or RC oscillator.
// - Clearing start mid-conversion aborts; result pair is kept.
// - A conversion lasts twelve bit periods, or eleven and part of one on the RC oscillator.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module adcpr_top
    import adcpr_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic COMP_I,
    input wire logic RC_CLK_I,
    output logic SAMPLE_O,
    output logic [9:0] SAR_CODE_O,
    output logic [2:0] CHAN_SEL_O,
    output logic [7:0] ANALOG_EN_O,
    output logic VREF_P_EXT_O,
    output logic VREF_N_EXT_O,
    output logic POWER_O,
    output logic DONE_O
);

    // ****************************************
    // Registers and internal state
    // ****************************************
    logic [7:0] ctrl;
    logic [7:0] pcfg;
    adcpr_result_t result;
    logic done_flag;
    adcpr_state_t state;
    adcpr_state_t next_state;
    logic [4:0] div_cnt;
    logic [3:0] tad_cnt;
    logic [9:0] sar;
    logic comp_s1;
    logic comp_s2;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
    logic tad_tick;
    logic [4:0] div_last;
    logic conv_end;
    logic abort;
    logic wr_en;
    logic acc_en;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic mapped;
    logic [3:0] bit_idx;
    adcpr_pins_t pins;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
        end else begin
            comp_s1 <= COMP_I;
            comp_s2 <= comp_s1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
            rc_s3 <= 1'b0;
        end else begin
            rc_s1 <= RC_CLK_I;
            rc_s2 <= rc_s1;
            rc_s3 <= rc_s2;
        end
    end

    // ****************************************
    // APB decode
    // ****************************************
    assign acc_en = PSEL_I && PENABLE_I && PREADY_O;
    assign wr_en = acc_en && PWRITE_I && PSTRB_I[0];
    assign wbyte = PWDATA_I[7:0];

    always_comb begin
        mapped = 1'b1;
        rbyte = 8'h00;
        unique case (PADDR_I)
            ADDR_CTRL: rbyte = ctrl;
            ADDR_PCFG: rbyte = pcfg & PCFG_WMASK;
            ADDR_RES_HI: rbyte = result.high;
            ADDR_RES_LO: rbyte = result.low;
            ADDR_STAT: rbyte = {1'b0, done_flag, 6'h00};
            default: mapped = 1'b0;
        endcase
    end

    // Answer one cycle into the access phase
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end else begin
            PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
            PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && !mapped;
            if (PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I) begin
                PRDATA_O <= {24'h00_0000, rbyte};
            end
        end
    end

    // ****************************************
    // Bit period divider
    // ****************************************
    always_comb begin
        unique case (ctrl[CTRL_CS_HI:CTRL_CS_LO])
            CS_DIV2: div_last = DIV2_LAST;
            CS_DIV8: div_last = DIV8_LAST;
            CS_DIV32: div_last = DIV32_LAST;
            default: div_last = DIV32_LAST;
        endcase
    end

    always_comb begin
        if (ctrl[CTRL_CS_HI:CTRL_CS_LO] == 2'h3) begin
            tad_tick = rc_s2 && !rc_s3;
        end else begin
            tad_tick = (div_cnt >= div_last);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            div_cnt <= 5'h00;
        end else if (state == ST_OFF || state == ST_ACQ || tad_tick
                     || abort) begin
            div_cnt <= 5'h00;
        end else begin
            div_cnt <= div_cnt + 5'h01;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    assign conv_end = (state == ST_CONV) && tad_tick
                      && (tad_cnt == TAD_PER_CONV - 4'h1);
    assign abort = (state == ST_CONV) && wr_en && (PADDR_I == ADDR_CTRL)
                   && !wbyte[CTRL_GO];

    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: begin
                if (ctrl[CTRL_ON]) begin
                    next_state = ST_ACQ;
                end
            end
            ST_ACQ: begin
                if (ctrl[CTRL_GO]) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_end || abort) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tad_tick && tad_cnt == TAD_POST_WAIT - 4'h1) begin
                    next_state = ST_ACQ;
                end
            end
        endcase
        if (!ctrl[CTRL_ON]) begin
            next_state = ST_OFF;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            tad_cnt <= 4'h0;
        end else if (state != next_state) begin
            tad_cnt <= 4'h0;
        end else if (tad_tick) begin
            tad_cnt <= tad_cnt + 4'h1;
        end
    end

    // ****************************************
    // Successive approximation
    // ****************************************
    assign bit_idx = 4'hA - tad_cnt;

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            sar <= 10'h000;
        end else if (state == ST_ACQ) begin
            sar <= SAR_MSB;
        end else if (state == ST_CONV && tad_tick && tad_cnt >= 4'h1
                     && tad_cnt <= 4'hA) begin
            sar[bit_idx] <= comp_s2;
            if (bit_idx != 4'h0) begin
                sar[bit_idx - 4'h1] <= 1'b1;
            end
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            ctrl <= CTRL_RESET;
        end else begin
            if (wr_en && PADDR_I == ADDR_CTRL) begin
                ctrl <= wbyte & CTRL_WMASK;
                if (!ctrl[CTRL_ON]) begin
                    ctrl[CTRL_GO] <= 1'b0;
                end
            end
            if (conv_end) begin
                ctrl[CTRL_GO] <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            pcfg <= PCFG_RESET;
        end else if (wr_en && PADDR_I == ADDR_PCFG) begin
            pcfg <= wbyte & PCFG_WMASK;
        end
    end

    // ****************************************
    // Result pair and done flag
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            result <= '{high: RES_RESET, low: RES_RESET};
        end else if (conv_end) begin
            result <= adcpr_justify(pcfg[PCFG_JUST], sar);
        end else begin
            if (wr_en && PADDR_I == ADDR_RES_HI) begin
                result.high <= wbyte;
            end
            if (wr_en && PADDR_I == ADDR_RES_LO) begin
                result.low <= wbyte;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            done_flag <= 1'b0;
        end else if (conv_end) begin
            done_flag <= 1'b1;
        end else if (wr_en && PADDR_I == ADDR_STAT) begin
            done_flag <= wbyte[STAT_DONE];
        end
    end

    // ****************************************
    // Analog side outputs
    // ****************************************
    assign pins = adcpr_decode(pcfg[3:0]);

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            ANALOG_EN_O <= 8'hFF;
            VREF_P_EXT_O <= 1'b0;
            VREF_N_EXT_O <= 1'b0;
        end else begin
            ANALOG_EN_O <= pins.analog;
            VREF_P_EXT_O <= pins.vref_p_ext;
            VREF_N_EXT_O <= pins.vref_n_ext;
        end
    end

    // No discharge path exists; sampling switch only
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            SAMPLE_O <= 1'b0;
        end else begin
            SAMPLE_O <= (next_state == ST_ACQ);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            SAR_CODE_O <= 10'h000;
            CHAN_SEL_O <= 3'h0;
            POWER_O <= 1'b0;
            DONE_O <= 1'b0;
        end else begin
            SAR_CODE_O <= sar;
            CHAN_SEL_O <= ctrl[CTRL_CH_HI:CTRL_CH_LO];
            POWER_O <= ctrl[CTRL_ON];
            DONE_O <= done_flag;
        end
    end

endmodule

`default_nettype wire

//--- hw/adcpr_pkg.sv
// Package for the converter port configuration and result control block.
// Assumes a 32-bit APB slave with word-aligned registers.
package adcpr_pkg;

    // ****************************************
    // Register indices; byte address is four times the index
    // ****************************************
    localparam logic [7:0] IDX_RES_HI = 8'h1E;
    localparam logic [7:0] IDX_RES_LO = 8'h9E;
    localparam logic [7:0] IDX_CTRL = 8'h1F;
    localparam logic [7:0] IDX_PCFG = 8'h9F;
    localparam logic [7:0] IDX_STAT = 8'h0C;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_RES_HI = {2'h0, IDX_RES_HI, 2'h0};
    localparam logic [11:0] ADDR_RES_LO = {2'h0, IDX_RES_LO, 2'h0};
    localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] ADDR_PCFG = {2'h0, IDX_PCFG, 2'h0};
    localparam logic [11:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CTRL_CS_HI = 7;
    localparam int CTRL_CS_LO = 6;
    localparam int CTRL_CH_HI = 5;
    localparam int CTRL_CH_LO = 3;
    localparam int CTRL_GO = 2;
    localparam int CTRL_ON = 0;
    localparam logic [7:0] CTRL_WMASK = 8'hFD;
    localparam int PCFG_JUST = 7;
    localparam logic [7:0] PCFG_WMASK = 8'h8F;
    localparam int STAT_DONE = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PCFG_RESET = 8'h00;
    localparam logic [7:0] RES_RESET = 8'h00;

    // ****************************************
    // Timing counts in bit conversion periods and clocks
    // ****************************************
    localparam logic [3:0] TAD_PER_CONV = 4'hC;
    localparam logic [3:0] TAD_POST_WAIT = 4'h2;
    localparam logic [1:0] CS_DIV2 = 2'h0;
    localparam logic [1:0] CS_DIV8 = 2'h1;
    localparam logic [1:0] CS_DIV32 = 2'h2;
    localparam logic [4:0] DIV2_LAST = 5'h01;
    localparam logic [4:0] DIV8_LAST = 5'h07;
    localparam logic [4:0] DIV32_LAST = 5'h1F;
    localparam logic [9:0] SAR_MSB = 10'h200;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_ACQ = 2'b01,
        ST_CONV = 2'b10,
        ST_WAIT = 2'b11
    } adcpr_state_t;

    typedef struct packed {
        logic [7:0] analog;
        logic vref_p_ext;
        logic vref_n_ext;
    } adcpr_pins_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } adcpr_result_t;

    // Per-pin analog mask and reference sources for a port code
    function automatic adcpr_pins_t adcpr_decode(input logic [3:0] code);
        adcpr_pins_t p;
        p = '{analog: 8'h00, vref_p_ext: 1'b0, vref_n_ext: 1'b0};
        unique case (code)
            4'h0: p = '{8'hFF, 1'b0, 1'b0};
            4'h1: p = '{8'hF7, 1'b1, 1'b0};
            4'h2: p = '{8'h1F, 1'b0, 1'b0};
            4'h3: p = '{8'h17, 1'b1, 1'b0};
            4'h4: p = '{8'h0B, 1'b0, 1'b0};
            4'h5: p = '{8'h03, 1'b1, 1'b0};
            4'h6, 4'h7: p = '{8'h00, 1'b0, 1'b0};
            4'h8: p = '{8'hF3, 1'b1, 1'b1};
            4'h9: p = '{8'h3F, 1'b0, 1'b0};
            4'hA: p = '{8'h37, 1'b1, 1'b0};
            4'hB: p = '{8'h33, 1'b1, 1'b1};
            4'hC: p = '{8'h13, 1'b1, 1'b1};
            4'hD: p = '{8'h03, 1'b1, 1'b1};
            4'hE: p = '{8'h01, 1'b0, 1'b0};
            4'hF: p = '{8'h01, 1'b1, 1'b1};
        endcase
        return p;
    endfunction

    // Place a 10-bit result in the byte pair, extra bits zero
    function automatic adcpr_result_t adcpr_justify(input logic right,
                                                   input logic [9:0] r);
        adcpr_result_t v;
        if (right) begin
            v = '{high: {6'h00, r[9:8]}, low: r[7:0]};
        end else begin
            v = '{high: r[9:2], low: {r[1:0], 6'h00}};
        end
        return v;
    endfunction

endpackage

//--- bench/adcpr_assertions.sv
// Checker for the converter control block, bound to its top module.
// Assumes software never sets the done flag by a register write.
`timescale 1ns/1ps
`default_nettype none

module adcpr_checker
    import adcpr_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic SAMPLE_O,
    input wire logic [7:0] ANALOG_EN_O,
    input wire logic VREF_P_EXT_O,
    input wire logic VREF_N_EXT_O,
    input wire logic POWER_O,
    input wire logic DONE_O
);
    logic xfer, rd, pcfg_wr, ctrl_wr, just;
    logic [7:0] low_cnt;
    assign xfer = PSEL_I && PENABLE_I && PREADY_O;
    assign rd = xfer && !PWRITE_I;
    assign pcfg_wr = xfer && PWRITE_I && PSTRB_I[0] && PADDR_I == ADDR_PCFG;
    assign ctrl_wr = xfer && PWRITE_I && PSTRB_I[0] && PADDR_I == ADDR_CTRL;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // ****
    // Justify bit and hold switch open time
    // ****
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            just <= 1'b0;
        end else if (pcfg_wr) begin
            just <= PWDATA_I[PCFG_JUST];
        end
    end
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I || SAMPLE_O) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hFF) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end
    a_right_just:
        assert property (rd && just && PADDR_I == ADDR_RES_HI
            |-> PRDATA_O[7:2] == 6'h00) else $error("high byte not right");
    a_left_just:
        assert property (rd && !just && PADDR_I == ADDR_RES_LO
            |-> PRDATA_O[5:0] == 6'h00) else $error("low byte not left");
    a_pcfg_unimpl:
        assert property (rd && PADDR_I == ADDR_PCFG
            |-> PRDATA_O[6:4] == 3'h0) else $error("bits 6-4 not zero");
    a_digital_codes:
        assert property (pcfg_wr && PWDATA_I[3:1] == 3'h3
            |-> ##2 ANALOG_EN_O == 8'h00) else $error("analog pin left");
    a_ext_refs:
        assert property (pcfg_wr && PWDATA_I[3:0] == 4'h8 |-> ##2
            VREF_P_EXT_O && VREF_N_EXT_O && ANALOG_EN_O == 8'hF3)
        else $error("external reference decode wrong");
    a_start_begins:
        assert property (ctrl_wr && PWDATA_I[CTRL_GO] && PWDATA_I[CTRL_ON]
            && POWER_O && SAMPLE_O |-> ##[1:4] !SAMPLE_O)
        else $error("start did not begin conversion");
    a_post_wait:
        assert property ($rose(DONE_O) |-> !SAMPLE_O [*3])
        else $error("sampling resumed too soon");
    a_conv_length:
        assert property ($rose(DONE_O) |-> low_cnt >= 8'h14)
        else $error("conversion too short");
    a_abort_quiet:
        assert property (ctrl_wr && !PWDATA_I[CTRL_GO] && PWDATA_I[CTRL_ON]
            && POWER_O && !SAMPLE_O && !DONE_O |=> !DONE_O [*8])
        else $error("aborted conversion raised done");
    c_done: cover property ($rose(DONE_O));
    c_abort: cover property (ctrl_wr && !PWDATA_I[CTRL_GO] && !SAMPLE_O);
    c_start: cover property (ctrl_wr && PWDATA_I[CTRL_GO] && SAMPLE_O);
endmodule

bind adcpr_top adcpr_checker u_checker (.CLK_I(CLK_I),
    .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .SAMPLE_O(SAMPLE_O), .ANALOG_EN_O(ANALOG_EN_O),
    .VREF_P_EXT_O(VREF_P_EXT_O), .VREF_N_EXT_O(VREF_N_EXT_O),
    .POWER_O(POWER_O), .DONE_O(DONE_O));
`default_nettype wire

//--- bench/adcpr_analog_model.sv
// Analog side: held input level, comparator and free RC oscillator.
// Assumes the level input is settled while the hold switch is closed.
`timescale 1ns/1ps
`default_nettype none

module adcpr_analog_model #(
    parameter int RC_HALF_NS = 130
) (
    input wire logic [9:0] level_i,
    input wire logic [9:0] code_i,
    input wire logic sample_i,
    output logic comp_o,
    output logic rc_clk_o
);
    logic [9:0] held = 10'h000;
    // Charge kept while the switch is open
    always @(sample_i or level_i) begin
        if (sample_i) begin
            held = level_i;
        end
    end
    assign comp_o = held >= code_i;
    initial begin
        rc_clk_o = 1'b0;
        forever #(RC_HALF_NS) rc_clk_o = ~rc_clk_o;
    end
endmodule
`default_nettype wire

//--- bench/test_adc_port_config_result_control.sv
// Self-checking bench for the converter control block.
// Assumes the analog model on the far side and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module test_adc_port_config_result_control
    import adcpr_pkg::*;
;
    localparam logic [9:0] PIN_TAB [16] = '{10'h3FC, 10'h3DE, 10'h07C,
        10'h05E, 10'h02C, 10'h00E, 10'h000, 10'h000, 10'h3CF, 10'h0FC,
        10'h0DE, 10'h0CF, 10'h04F, 10'h00F, 10'h004, 10'h007};
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, comp, rc_clk;
    logic sample, vref_p, vref_n, power, done, last_j;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [9:0] sar_code, level, last_lv;
    logic [2:0] chan_sel;
    logic [7:0] analog_en;
    int n_fail, samples_checked;
    integer seed;

    adcpr_top DUT (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .COMP_I(comp),
        .RC_CLK_I(rc_clk), .SAMPLE_O(sample), .SAR_CODE_O(sar_code),
        .CHAN_SEL_O(chan_sel), .ANALOG_EN_O(analog_en),
        .VREF_P_EXT_O(vref_p), .VREF_N_EXT_O(vref_n), .POWER_O(power),
        .DONE_O(done));
    adcpr_analog_model MODEL (.level_i(level), .code_i(sar_code),
        .sample_i(sample), .comp_o(comp), .rc_clk_o(rc_clk));

    function automatic logic [15:0] exp_res(input logic j,
                                            input logic [9:0] r);
        return j ? {6'h00, r} : {r, 6'h00};
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 8'h00, r, e);
    endtask

    task automatic arm(input logic [1:0] cs, input logic j,
                       input logic [9:0] lv);
        int n;
        n = 0;
        level <= lv;
        wr(ADDR_PCFG, {j, 7'h00});
        wr(ADDR_STAT, 8'h00);
        wr(ADDR_CTRL, {cs, 6'h09});
        while (sample !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) begin
            n_fail++;
        end
        repeat (20) @(posedge clk);
        wr(ADDR_CTRL, {cs, 6'h0D});
    endtask

    task automatic convert(input logic [1:0] cs, input logic j,
                           input logic [9:0] lv);
        logic [31:0] hi, lo;
        int n, t;
        n = 0;
        t = 2 << (2 * cs);
        arm(cs, j, lv);
        rd(ADDR_CTRL, hi);
        cmp(hi[CTRL_GO], 1);
        cmp({power, chan_sel}, 4'h9);
        while (done !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) begin
            n_fail++;
        end
        if (cs != 2'h3) begin
            cmp(n + 5 >= 12 * t && n + 5 <= 13 * t + 6, 1);
        end
        rd(ADDR_CTRL, hi);
        cmp(hi[CTRL_GO], 0);
        rd(ADDR_STAT, hi);
        cmp(hi[STAT_DONE], 1);
        rd(ADDR_RES_HI, hi);
        rd(ADDR_RES_LO, lo);
        cmp({hi[7:0], lo[7:0]}, exp_res(j, lv));
        last_j = j;
        last_lv = lv;
    endtask

    task automatic finish_test;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    // ****
    // Main sequence
    // ****
    initial begin
        logic [31:0] r, h;
        logic e;
        int i;
        seed = 32'h6759;
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        level = 10'h000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(ADDR_CTRL, r);
        cmp(r, {24'h000000, CTRL_RESET});
        apb(1'b0, 12'h004, 8'h00, r, e);
        cmp({r[30:0], e}, 32'h00000001);
        wr(ADDR_PCFG, 8'hFF);
        rd(ADDR_PCFG, r);
        cmp(r, 32'h0000008F);
        for (i = 0; i < 16; i++) begin
            wr(ADDR_PCFG, 8'(i));
            @(posedge clk);
            cmp({analog_en, vref_p, vref_n}, PIN_TAB[i]);
        end
        for (i = 0; i < 10; i++) begin
            r = $random(seed);
            // Divide by two only at level zero; comparator sync is slower
            convert(i < 4 ? 2'(i) : 2'h1 + {1'b0, r[11]}, r[12],
                    i == 0 ? 10'h000 : i == 1 ? 10'h3FF : r[9:0]);
        end
        arm(2'h2, last_j, r[21:12]);
        repeat (40) @(posedge clk);
        wr(ADDR_CTRL, 8'h89);
        repeat (500) @(posedge clk);
        cmp(done, 0);
        rd(ADDR_RES_HI, h);
        rd(ADDR_RES_LO, r);
        cmp({h[7:0], r[7:0]}, exp_res(last_j, last_lv));
        finish_test();
    end
endmodule
`default_nettype wire
